// ### src/fault_check_consts.vh
// constants for the legacy remap fault classifier
`ifndef FAULT_CHECK_CONSTS_VH
`define FAULT_CHECK_CONSTS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFF_CTRL 12'h000
`define OFF_CAP 12'h004
`define OFF_STATUS 12'h008
`define OFF_CLEAR 12'h00C
`define OFF_ENABLE 12'h010
`define OFF_LAST 12'h014

// ----------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 1
`define CTRL_RST 32'h0000_0000
`define MODE_LEGACY 2'h0
`define CAP_GUEST_LSB 0
`define CAP_GUEST_MSB 6
`define CAP_HOST_LSB 8
`define CAP_HOST_MSB 14
`define CAP_ZERO_READ_BIT 16
`define CAP_RST 32'h0001_2F2F

// ----------------------------------------------------------------
// request classes, translation type, responses
// ----------------------------------------------------------------
`define RQ_UNTRANSLATED 2'h0
`define RQ_TRANSLATION 2'h1
`define RQ_TRANSLATED 2'h2
`define XLATE_PASS_THROUGH 2'h2
`define RSP_OK 2'h0
`define RSP_UR 2'h1
`define RSP_CA 2'h2
`define RSP_SUCCESS_PERM 2'h3

// ----------------------------------------------------------------
// fault reasons
// ----------------------------------------------------------------
`define FR_NONE 8'h00
`define FR_OVERFLOW 8'h04
`define FR_NO_WRITE 8'h05
`define FR_NO_READ 8'h06
`define FR_NEXT_FETCH 8'h07
`define FR_RSVD 8'h0C

`endif

// ### src/fault_classify.v
// combinational fault classification of one legacy-mode request
`timescale 1ns/1ps
module fault_classify (
    // mode and capability
    input wire [1:0] translation_table_mode,
    input wire [6:0] max_guest_address_width,
    input wire [6:0] host_address_width,
    input wire zero_length_read_support,
    // request
    input wire [1:0] req_class,
    input wire req_pasid,
    input wire [1:0] translation_type,
    input wire [6:0] context_address_width,
    input wire [63:0] req_addr,
    input wire req_read,
    input wire req_write,
    input wire req_zero_length,
    // walk results
    input wire walk_fetch_error,
    input wire walk_rsvd_nonzero,
    input wire walk_entry_perm_set,
    input wire perm_read,
    input wire perm_write,
    // result
    output reg fault,
    output reg qualified,
    output reg [7:0] reason,
    output reg [1:0] response,
    output reg [3:0] ret_perm
);
`include "fault_check_consts.vh"
    reg [6:0] x_width;
    reg [64:0] lim_x;
    reg [64:0] lim_h;
    reg ovf_x;
    reg ovf_h;
    reg untr;
    reg trq;
    always @* begin
        x_width = (max_guest_address_width < context_address_width) ?
            max_guest_address_width : context_address_width;
        lim_x = 65'h1_0000_0000_0000_0000 >> (7'h40 - x_width);
        lim_h = 65'h1_0000_0000_0000_0000 >> (7'h40 - host_address_width);
        ovf_x = ({1'b0, req_addr} >= lim_x) && (x_width < 7'h40);
        ovf_h = ({1'b0, req_addr} >= lim_h) && (host_address_width < 7'h40);
        untr = (req_class == `RQ_UNTRANSLATED) && !req_pasid;
        trq = (req_class == `RQ_TRANSLATION) && !req_pasid;
        fault = 1'b0;
        qualified = 1'b0;
        reason = `FR_NONE;
        response = `RSP_OK;
        ret_perm = {2'b00, perm_write, perm_read};
        if (translation_table_mode == `MODE_LEGACY) begin
            if ((untr || trq) && walk_fetch_error) begin
                fault = 1'b1;
                reason = `FR_NEXT_FETCH;
                response = untr ? `RSP_UR : `RSP_CA;
            end else if ((untr || trq) && walk_rsvd_nonzero &&
                walk_entry_perm_set) begin
                fault = 1'b1;
                reason = `FR_RSVD;
                response = untr ? `RSP_UR : `RSP_CA;
            end else if ((req_class == `RQ_TRANSLATED) && !req_pasid &&
                ovf_h) begin
                fault = 1'b1;
                reason = `FR_OVERFLOW;
                response = `RSP_UR;
            end else if (untr && translation_type == `XLATE_PASS_THROUGH &&
                ovf_h) begin
                fault = 1'b1;
                reason = `FR_OVERFLOW;
                response = `RSP_UR;
            end else if ((untr || trq) &&
                translation_type != `XLATE_PASS_THROUGH && ovf_x) begin
                fault = 1'b1;
                reason = `FR_OVERFLOW;
                response = untr ? `RSP_UR : `RSP_SUCCESS_PERM;
                ret_perm = 4'h0;
            end else if ((untr || trq) && req_write && !perm_write) begin
                fault = 1'b1;
                reason = `FR_NO_WRITE;
                response = untr ? `RSP_UR : `RSP_SUCCESS_PERM;
            end else if ((untr || trq) && req_read && !perm_read &&
                !(zero_length_read_support && req_zero_length &&
                !req_write && perm_write)) begin
                fault = 1'b1;
                reason = `FR_NO_READ;
                response = untr ? `RSP_UR : `RSP_SUCCESS_PERM;
            end
            qualified = fault;
        end
    end
endmodule // fault_classify

// ### src/legacy_dma_remap_fault_check.v
// legacy-mode remap fault checker with apb registers and interrupt
//
// Contract
// - checks act only when the translation table mode is legacy 00b.
// - failed next-level entry fetch gives qualified 7h, UR / CA.
// - reserved bits set in an entry with R or W give qualified Ch, UR / CA.
// - address above 2^X-1, X the smaller address width, gives qualified 4h.
// - that overflow answers UR untranslated, success with perms 0 for ATS.
// - translated request above host width gives qualified 4h and UR.
// - pass-through untranslated above host width gives qualified 4h, UR.
// - write or atomic without write permission gives 5h, UR / success.
// - read or atomic without read permission gives 6h, UR / success.
// - zero-length read of a write-only page, when supported, is no fault.
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
module legacy_dma_remap_fault_check (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // request in, same clock
    input wire req_valid,
    input wire [1:0] req_class,
    input wire req_pasid,
    input wire [1:0] translation_type,
    input wire [6:0] context_address_width,
    input wire [63:0] req_addr,
    input wire req_read,
    input wire req_write,
    input wire req_zero_length,
    input wire walk_fetch_error,
    input wire walk_rsvd_nonzero,
    input wire walk_entry_perm_set,
    input wire perm_read,
    input wire perm_write,
    // result out
    output reg rsp_valid_ff,
    output reg rsp_fault_ff,
    output reg rsp_qualified_ff,
    output reg [7:0] rsp_reason_ff,
    output reg [1:0] rsp_code_ff,
    output reg [3:0] rsp_perm_ff,
    // interrupt
    output wire irq
);
`include "fault_check_consts.vh"

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [31:0] ctrl_ff;
    reg [31:0] cap_ff;
    reg [2:0] status_ff;
    reg [2:0] enable_ff;
    reg [7:0] last_reason_ff;
    reg [2:0] nxt_status;
    wire fault;
    wire qualified;
    wire [7:0] reason;
    wire [1:0] response;
    wire [3:0] ret_perm;
    wire wr_en;
    wire rd_en;
    wire [2:0] ev;

    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pslverr = psel && penable && !(paddr == `OFF_CTRL ||
        paddr == `OFF_CAP || paddr == `OFF_STATUS ||
        paddr == `OFF_CLEAR || paddr == `OFF_ENABLE ||
        paddr == `OFF_LAST);

    // ------------------------------------------------------------
    // classifier
    // ------------------------------------------------------------
    fault_classify u_classify (
        .translation_table_mode(ctrl_ff[`CTRL_MODE_MSB:`CTRL_MODE_LSB]),
        .max_guest_address_width(cap_ff[`CAP_GUEST_MSB:`CAP_GUEST_LSB]),
        .host_address_width(cap_ff[`CAP_HOST_MSB:`CAP_HOST_LSB]),
        .zero_length_read_support(cap_ff[`CAP_ZERO_READ_BIT]),
        .req_class(req_class),
        .req_pasid(req_pasid),
        .translation_type(translation_type),
        .context_address_width(context_address_width),
        .req_addr(req_addr),
        .req_read(req_read),
        .req_write(req_write),
        .req_zero_length(req_zero_length),
        .walk_fetch_error(walk_fetch_error),
        .walk_rsvd_nonzero(walk_rsvd_nonzero),
        .walk_entry_perm_set(walk_entry_perm_set),
        .perm_read(perm_read),
        .perm_write(perm_write),
        .fault(fault),
        .qualified(qualified),
        .reason(reason),
        .response(response),
        .ret_perm(ret_perm)
    );

    // events: fault, ur answer, ca answer
    assign ev = {req_valid && response == `RSP_CA,
        req_valid && response == `RSP_UR, req_valid && fault};

    // ------------------------------------------------------------
    // result register
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_valid_ff <= 1'b0;
            rsp_fault_ff <= 1'b0;
            rsp_qualified_ff <= 1'b0;
            rsp_reason_ff <= `FR_NONE;
            rsp_code_ff <= `RSP_OK;
            rsp_perm_ff <= 4'h0;
        end else begin
            rsp_valid_ff <= req_valid;
            rsp_fault_ff <= req_valid && fault;
            rsp_qualified_ff <= req_valid && qualified;
            rsp_reason_ff <= req_valid ? reason : `FR_NONE;
            rsp_code_ff <= req_valid ? response : `RSP_OK;
            rsp_perm_ff <= req_valid ? ret_perm : 4'h0;
        end
    end

    // ------------------------------------------------------------
    // status, set wins over clear
    // ------------------------------------------------------------
    always @* begin
        nxt_status = status_ff;
        if (wr_en && paddr == `OFF_CLEAR) begin
            nxt_status = status_ff & ~pwdata[2:0];
        end
        nxt_status = nxt_status | ev;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `CTRL_RST;
            cap_ff <= `CAP_RST;
            status_ff <= 3'h0;
            enable_ff <= 3'h0;
            last_reason_ff <= `FR_NONE;
        end else begin
            status_ff <= nxt_status;
            if (req_valid && fault) begin
                last_reason_ff <= reason;
            end
            if (wr_en && paddr == `OFF_CTRL) begin
                ctrl_ff <= {30'h0, pwdata[1:0]};
            end
            if (wr_en && paddr == `OFF_CAP) begin
                cap_ff <= {15'h0, pwdata[16], 1'b0, pwdata[14:8],
                    1'b0, pwdata[6:0]};
            end
            if (wr_en && paddr == `OFF_ENABLE) begin
                enable_ff <= pwdata[2:0];
            end
        end
    end

    assign irq = |(status_ff & enable_ff);

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always @* begin
        prdata = 32'h0;
        if (rd_en) begin
            case (paddr)
                `OFF_CTRL: prdata = ctrl_ff;
                `OFF_CAP: prdata = cap_ff;
                `OFF_STATUS: prdata = {29'h0, status_ff};
                `OFF_ENABLE: prdata = {29'h0, enable_ff};
                `OFF_LAST: prdata = {24'h0, last_reason_ff};
                default: prdata = 32'h0;
            endcase
        end
    end
endmodule // legacy_dma_remap_fault_check

// ### verif/fault_check_monitor.sv
// checker for the legacy remap fault classifier
`timescale 1ns/1ps
`include "fault_check_consts.vh"
module fault_check_monitor (
    // apb and clock
    input wire pclk, presetn, psel, penable, pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    // request
    input wire req_valid, req_pasid, req_read, req_write,
    input wire [1:0] req_class, translation_type,
    input wire [6:0] context_address_width,
    input wire [63:0] req_addr,
    input wire walk_fetch_error, walk_rsvd_nonzero, walk_entry_perm_set,
    input wire perm_read, perm_write, req_zero_length,
    // result
    input wire rsp_valid_ff, rsp_fault_ff, rsp_qualified_ff,
    input wire [7:0] rsp_reason_ff,
    input wire [1:0] rsp_code_ff,
    input wire [3:0] rsp_perm_ff
);
reg [1:0] mode_ff;
reg [6:0] guest_w_ff, host_w_ff;
reg zero_rd_ff;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        {mode_ff, guest_w_ff, host_w_ff, zero_rd_ff} <=
            {2'h0, 7'h2F, 7'h2F, 1'b1};
    end else if (psel && penable && pwrite && paddr == `OFF_CTRL) begin
        mode_ff <= pwdata[1:0];
    end else if (psel && penable && pwrite && paddr == `OFF_CAP) begin
        {zero_rd_ff, host_w_ff, guest_w_ff} <=
            {pwdata[16], pwdata[14:8], pwdata[6:0]};
    end
end
wire [6:0] x = guest_w_ff < context_address_width ? guest_w_ff
    : context_address_width;
wire ovx = x < 7'h40 && (req_addr >> x) != 64'h0;
wire ovh = host_w_ff < 7'h40 && (req_addr >> host_w_ff) != 64'h0;
wire base = req_valid && mode_ff == 2'h0 && !req_pasid;
wire ut = base && req_class == `RQ_UNTRANSLATED;
wire tr = base && req_class == `RQ_TRANSLATION;
wire ok = !walk_fetch_error && !(walk_rsvd_nonzero && walk_entry_perm_set);
wire pt = translation_type == `XLATE_PASS_THROUGH;
wire up = ut && ok && !pt && !ovx;
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
chk_rsp_latency: assert property (req_valid |=> rsp_valid_ff)
    else $error("no response");
chk_mode_gate: assert property (req_valid && mode_ff != 2'h0
    |=> !rsp_fault_ff)
    else $error("fault outside legacy");
chk_fetch_ur: assert property (ut && walk_fetch_error |=>
    rsp_qualified_ff && rsp_reason_ff == `FR_NEXT_FETCH
    && rsp_code_ff == `RSP_UR)
    else $error("fetch fault bad");
chk_fetch_ca: assert property (tr && walk_fetch_error |=>
    rsp_reason_ff == `FR_NEXT_FETCH && rsp_code_ff == `RSP_CA)
    else $error("fetch abort bad");
chk_rsvd_entry: assert property ((ut || tr) && !walk_fetch_error
    && walk_rsvd_nonzero && walk_entry_perm_set
    |=> rsp_qualified_ff && rsp_reason_ff == `FR_RSVD)
    else $error("reserved fault bad");
chk_ovf_ats: assert property (tr && ok && !pt && ovx |=>
    rsp_perm_ff == 4'h0 && rsp_reason_ff == `FR_OVERFLOW
    && rsp_code_ff == `RSP_SUCCESS_PERM)
    else $error("overflow success bad");
chk_ovf_host: assert property (base && ok && ovh
    && (req_class == `RQ_TRANSLATED || req_class == `RQ_UNTRANSLATED && pt)
    |=> rsp_reason_ff == `FR_OVERFLOW && rsp_code_ff == `RSP_UR)
    else $error("host width fault bad");
chk_write_perm: assert property (up && req_write && !perm_write |=>
    rsp_reason_ff == `FR_NO_WRITE && rsp_code_ff == `RSP_UR)
    else $error("write perm fault bad");
chk_read_perm: assert property (up && req_read && !req_write
    && !perm_read && !(perm_write && req_zero_length)
    |=> rsp_reason_ff == `FR_NO_READ)
    else $error("read perm fault bad");
chk_zero_len_skip: assert property (up && zero_rd_ff && req_read
    && !req_write && req_zero_length && perm_write && !perm_read
    |=> !rsp_fault_ff)
    else $error("zero length read faulted");
cov_fetch: cover property (ut && walk_fetch_error);
cov_ovf: cover property (tr && ovx);
cov_mode: cover property (req_valid && mode_ff != 2'h0);
cov_zero_len: cover property (up && zero_rd_ff && req_read && !req_write
    && req_zero_length && perm_write && !perm_read);
endmodule // fault_check_monitor
bind legacy_dma_remap_fault_check fault_check_monitor u_mon (.*);

// ### verif/dma_requester.sv
// dma requester model driving one request per call
`timescale 1ns/1ps
module dma_requester (
    // clock
    input wire pclk,
    // request
    output logic req_valid,
    output wire req_pasid, req_read, req_write, req_zero_length,
    output wire [1:0] req_class, translation_type,
    output wire [6:0] context_address_width,
    output wire [63:0] req_addr,
    output wire walk_fetch_error, walk_rsvd_nonzero, walk_entry_perm_set,
    output wire perm_read, perm_write
);
logic [83:0] bus = 84'h0;
assign {req_class, req_pasid, translation_type, context_address_width,
    req_addr, req_read, req_write, req_zero_length, walk_fetch_error,
    walk_rsvd_nonzero, walk_entry_perm_set, perm_read, perm_write} = bus;
initial req_valid = 1'b0;
task send(input logic [83:0] f);
    @(posedge pclk);
    req_valid <= 1'b1;
    bus <= f;
    @(posedge pclk);
    req_valid <= 1'b0;
    bus <= ~f;
endtask
endmodule // dma_requester

// ### verif/legacy_dma_remap_fault_check_bench.sv
// self-checking bench for the legacy remap fault checker
`timescale 1ns/1ps
`include "fault_check_consts.vh"
module legacy_dma_remap_fault_check_bench;
logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se;
logic [11:0] paddr = 0;
logic [31:0] pwdata = 0, rd;
wire pready, pslverr, irq, req_valid, req_pasid, req_read, req_write;
wire req_zero_length, walk_fetch_error, walk_rsvd_nonzero;
wire walk_entry_perm_set, perm_read, perm_write;
wire rsp_valid_ff, rsp_fault_ff, rsp_qualified_ff;
wire [1:0] req_class, translation_type, rsp_code_ff;
wire [6:0] context_address_width;
wire [63:0] req_addr;
wire [31:0] prdata;
wire [7:0] rsp_reason_ff;
wire [3:0] rsp_perm_ff;
logic [1:0] mode = 0;
logic [6:0] guest_w = 7'h2F, host_w = 7'h2F;
logic zero_rd = 1;
int failures = 0, checks = 0, cyc = 0;
legacy_dma_remap_fault_check DUT (.*);
dma_requester u_req (.*);
initial forever #4 pclk = ~pclk;
always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
        failures++;
        conclude();
    end
end
task chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
        failures++;
        $display("BAD %0t got %h exp %h", $time, got, exp);
    end
endtask
task conclude;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    {rd, se} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
endtask
function logic [10:0] want(input logic [83:0] f);
    logic [1:0] c, t, ca, sp;
    logic p, q, w, z, fe, rs, ps, pr, pw, u, r, ovx, ovh;
    logic [6:0] cw, x;
    logic [63:0] a;
    {c, p, t, cw, a, q, w, z, fe, rs, ps, pr, pw} = f;
    x = guest_w < cw ? guest_w : cw;
    ovx = x < 64 && (a >> x) != 0;
    ovh = host_w < 64 && (a >> host_w) != 0;
    {u, r} = {c == 0, c == 1};
    ca = u ? `RSP_UR : `RSP_CA;
    sp = u ? `RSP_UR : `RSP_SUCCESS_PERM;
    want = 0;
    if (mode != 0 || p)
        want = 0;
    else if ((u || r) && fe)
        want = {1'b1, `FR_NEXT_FETCH, ca};
    else if ((u || r) && rs && ps)
        want = {1'b1, `FR_RSVD, ca};
    else if ((c == 2 || u && t == 2) && ovh)
        want = {1'b1, `FR_OVERFLOW, `RSP_UR};
    else if (t == 2 || c >= 2)
        want = 0;
    else if (ovx)
        want = {1'b1, `FR_OVERFLOW, sp};
    else if (w && !pw)
        want = {1'b1, `FR_NO_WRITE, sp};
    else if (q && !pr && !(zero_rd && z && !w && pw))
        want = {1'b1, `FR_NO_READ, sp};
endfunction
function logic [83:0] rnd;
    logic [1:0] c, t;
    logic [7:0] g;
    c = $urandom % 3;
    t = (c == 0 && $urandom % 3 == 0) ? 2'h2 : 2'h0;
    g = $urandom;
    g[4] = $urandom % 6 == 0;
    if (c == 2 || t == 2) g[4:0] = 5'b00011;
    rnd = {c, 1'($urandom % 8 == 0), t, 7'(30 + $urandom % 40),
        {$urandom, $urandom} >> ($urandom % 40), g};
endfunction
task run(input logic [83:0] f);
    logic [10:0] e;
    e = want(f);
    u_req.send(f);
    #1;
    chk(rsp_valid_ff, 1);
    chk(rsp_fault_ff, e[10]);
    if (e[10]) begin
        chk(rsp_reason_ff, e[9:2]);
        chk({rsp_qualified_ff, rsp_code_ff}, {1'b1, e[1:0]});
        if (e[9:2] == `FR_OVERFLOW && e[1:0] == `RSP_SUCCESS_PERM)
            chk(rsp_perm_ff, 0);
        else if (e[1:0] == `RSP_SUCCESS_PERM)
            chk(rsp_perm_ff, {2'b00, f[0], f[1]});
    end else begin
        chk({rsp_qualified_ff, rsp_reason_ff, rsp_code_ff}, 0);
    end
endtask
initial begin
    void'($urandom(32'hDAB7));
    repeat (12) @(posedge pclk);
    presetn <= 1;
    apb(0, `OFF_CAP, 0);
    chk(rd, `CAP_RST);
    apb(0, `OFF_CTRL, 0);
    chk(rd, `CTRL_RST);
    apb(0, 12'h0FC, 0);
    chk(se, 1);
    $display("registers done");
    repeat (400) run(rnd());
    run({5'h0, 7'd48, 64'h1000, 8'hA1});
    run({5'h8, 7'd48, 64'h0000_8000_0000_0000, 8'h03});
    run({5'h8, 7'd48, 64'h0000_7FFF_FFFF_FFFF, 8'h03});
    run({5'h8, 7'd48, 64'h0, 8'h1F});
    apb(1, `OFF_CAP, 32'h0000_3027);
    {guest_w, host_w, zero_rd} = {7'd39, 7'd48, 1'b0};
    run({5'h0, 7'd48, 64'h1000, 8'hA1});
    repeat (300) run(rnd());
    apb(1, `OFF_CTRL, 1);
    mode = 1;
    repeat (60) run(rnd());
    apb(1, `OFF_CTRL, 0);
    mode = 0;
    $display("random done");
    apb(1, `OFF_CLEAR, 7);
    apb(1, `OFF_ENABLE, 7);
    apb(0, `OFF_ENABLE, 0);
    chk(rd, 7);
    chk(irq, 0);
    run({5'h0, 7'd48, 64'h0, 8'h13});
    @(posedge pclk) #1 chk(irq, 1);
    apb(0, `OFF_LAST, 0);
    chk(rd[7:0], `FR_NEXT_FETCH);
    apb(1, `OFF_CLEAR, 7);
    @(posedge pclk) #1 chk(irq, 0);
    apb(1, `OFF_ENABLE, 0);
    run({5'h8, 7'd48, 64'h0, 8'h13});
    @(posedge pclk) #1 chk(irq, 0);
    apb(0, `OFF_STATUS, 0);
    chk(rd, 32'h0000_0005);
    apb(0, `OFF_CLEAR, 0);
    chk(rd, 0);
    $display("interrupt done");
    apb(1, `OFF_ENABLE, 7);
    @(posedge pclk) #1 chk(irq, 1);
    @(posedge pclk) presetn <= 0;
    repeat (3) @(posedge pclk);
    chk({irq, rsp_valid_ff, pslverr}, 0);
    presetn <= 1;
    {guest_w, host_w, zero_rd} = {7'h2F, 7'h2F, 1'b1};
    apb(0, `OFF_CAP, 0);
    chk(rd, `CAP_RST);
    apb(0, `OFF_STATUS, 0);
    chk(rd, 0);
    apb(0, `OFF_ENABLE, 0);
    chk(rd, 0);
    repeat (40) run(rnd());
    $display("reset done");
    conclude();
end
endmodule // legacy_dma_remap_fault_check_bench
